// ### src/alm_cfg.svh
// Constants of the line interface: offsets, bit positions, resets, timing.
// Assumes inclusion by the package only.
`ifndef ALM_CFG_SVH
`define ALM_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ALM_OFS_STATUS      3'h0
`define ALM_OFS_RECEIVE_BUFFER        3'h2
`define ALM_OFS_TCTL        3'h4
`define ALM_OFS_TBUF        3'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ALM_ST_MODEM_CHG    15
`define ALM_ST_RX_IE        6
`define ALM_ST_MODEM_IE     5
`define ALM_ST_SEC_TX       3
`define ALM_ST_RTS          2
`define ALM_ST_DTR          1
`define ALM_TC_BAUD_HI      15
`define ALM_TC_BAUD_LO      12
`define ALM_TC_BAUD_WE      11
`define ALM_TC_TX_IE        6
`define ALM_TC_LOOP         2
`define ALM_TC_BREAK        0

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ALM_BAUD_RST        4'h0
`define ALM_LINES_RST       5'h01
`define ALM_CLK_HZ          100000000
`define ALM_CNT_W           24
`define ALM_FIFO_DEPTH      2

`endif

// ### src/alm_line.sv
// Asynchronous serial line interface with modem control and four word registers.
// Assumes one 100 MHz clock, strap inputs that stay static, bus strobes on clk_in.
//
// How it works
// - Modem-change flag sets on carrier, cts, secondary edges, or ring rising.
// - Modem-change flag clears on bus reset or any status register read.
// - Modem interrupt request while change flag and modem enable bit 5 set.
// - Ring indication reads as status bit 14.
// - Clear-to-send reads as bit 13, carrier as bit 12; one means on.
// - Receiver-active sets mid start bit, clears at done or bus reset.
// - Secondary receive lead reads as bit 10, spacing reads one.
// - Receive-done sets per character, clears when receive buffer addressed or reset.
// - Receive interrupt request while done and receive enable bit 6 set.
// - Status bit 3 drives secondary transmit lead to spacing; reset clears it.
// - Status bit 2 drives request-to-send or force-busy per strap.
// - Status bit 1 drives terminal-ready; bus reset leaves it alone.
// - Buffer bit 15 is OR of error flags, not an interrupt source.
// - Error flags hold until the next character; bus reset clears them.
// - Overrun sets when a character completes while done still set.
// - Framing error sets when the stop bit is missing.
// - Parity error on mismatch; always zero with parity off.
// - Character right-justified in bits 7..0, unused bits zero, kept over bus reset.
// - Baud code bits 15..12 load only with enable bit 11 in same write.
// - Transmit-ready bit 7 while buffer has room; interrupt with enable bit 6.
// - Loopback bit 2 feeds transmit line to receiver, isolating external input.
// - Break bit 0 forces continuous spacing on the serial output.
// - Baud codes 0..15 give 50 up to 19200 baud.
// - Five to eight data bits chosen by a two-bit strap.
`timescale 1ns/10ps

module alm_line
    import alm_pkg::*;
#(
    parameter int CLK_HZ = `ALM_CLK_HZ
) (
    // Clock and resets
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        system_bus_reset_in,
    // Register port
    input  wire logic [2:0]  reg_addr_in,
    input  wire logic        reg_rd_in,
    input  wire logic        reg_wr_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic      [15:0] reg_rdata_out,
    // Interrupt requests
    output logic             rx_irq_out,
    output logic             modem_irq_out,
    output logic             tx_irq_out,
    // Static straps
    input  wire logic [1:0]  data_bits_in,
    input  wire logic        parity_en_in,
    input  wire logic        parity_odd_in,
    input  wire logic        rts_select_in,
    input  wire logic        split_speed_in,
    input  wire logic [3:0]  tx_baud_in,
    // Serial data and modem leads
    input  wire logic        rxd_in,
    input  wire logic        ring_in,
    input  wire logic        clear_to_send_in,
    input  wire logic        carrier_in,
    input  wire logic        secondary_rx_in,
    output logic             txd_out,
    output logic             terminal_ready_out,
    output logic             request_to_send_out,
    output logic             force_busy_out,
    output logic             secondary_tx_space_out,
    output logic             transmit_ready_out
);

    // ----------------------------------------
    // Baud divisor
    // ----------------------------------------
    function automatic logic [`ALM_CNT_W-1:0] bit_cycles(input logic [3:0] code);
        longint b10;
        b10 = 0;
        case (code)
            4'h0:    b10 = 500;
            4'h1:    b10 = 750;
            4'h2:    b10 = 1100;
            4'h3:    b10 = 1345;
            4'h4:    b10 = 1500;
            4'h5:    b10 = 3000;
            4'h6:    b10 = 6000;
            4'h7:    b10 = 12000;
            4'h8:    b10 = 18000;
            4'h9:    b10 = 20000;
            4'hA:    b10 = 24000;
            4'hB:    b10 = 36000;
            4'hC:    b10 = 48000;
            4'hD:    b10 = 72000;
            4'hE:    b10 = 96000;
            default: b10 = 192000;
        endcase
        bit_cycles = `ALM_CNT_W'((longint'(CLK_HZ) * 10) / b10);
    endfunction : bit_cycles

    alm_state_t st_r;
    alm_state_t st_nxt;

    logic [3:0]            nbits;
    logic [3:0]            tx_code;
    logic [3:0]            rx_code;
    logic [`ALM_CNT_W-1:0] tx_div;
    logic [`ALM_CNT_W-1:0] rx_div;
    logic                  rx_line;
    logic                  sel_st;
    logic                  sel_rb;
    logic                  sel_tc;
    logic                  sel_tb;
    logic                  tready;
    logic                  done_set;

    // ----------------------------------------
    // Static decodes
    // ----------------------------------------
    // Split speed: program sets receive rate (strap in loopback), strap sets transmit rate
    assign nbits   = 4'd5 + {2'b00, data_bits_in};
    assign tx_code = split_speed_in ? tx_baud_in : st_r.baud_code;
    assign rx_code = (split_speed_in && st_r.loop) ? tx_baud_in : st_r.baud_code;
    assign tx_div  = bit_cycles(tx_code);
    assign rx_div  = bit_cycles(rx_code);
    assign rx_line = st_r.loop ? st_r.txd : st_r.lines[0];
    assign tready  = (st_r.fill != 2'(`ALM_FIFO_DEPTH));

    // Bit 0 of the address is ignored
    always_comb begin
        sel_st = 1'b0;
        sel_rb = 1'b0;
        sel_tc = 1'b0;
        sel_tb = 1'b0;
        if (reg_addr_in[2:1] == `ALM_OFS_STATUS >> 1) begin
            sel_st = 1'b1;
        end else if (reg_addr_in[2:1] == `ALM_OFS_RECEIVE_BUFFER >> 1) begin
            sel_rb = 1'b1;
        end else if (reg_addr_in[2:1] == `ALM_OFS_TCTL >> 1) begin
            sel_tc = 1'b1;
        end else begin
            sel_tb = 1'b1;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic       push;
        logic       pop;
        push     = 1'b0;
        pop      = 1'b0;
        done_set = 1'b0;
        st_nxt   = st_r;

        // Three-stage sync; a change counts once stages two and three agree
        st_nxt.sync1 = {secondary_rx_in, carrier_in, clear_to_send_in, ring_in, rxd_in};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.sync3 = st_r.sync2;
        st_nxt.lines = (st_r.sync2 & st_r.sync3) | (st_r.lines & (st_r.sync2 | st_r.sync3));

        // Transmitter: start, data LSB first, parity, stop, idle mark
        case (st_r.tx_st)
            TX_IDLE: begin
                st_nxt.txd = 1'b1;
                if (st_r.fill != 2'd0) begin
                    pop           = 1'b1;
                    st_nxt.tx_st  = TX_SHIFT;
                    st_nxt.tx_cnt = tx_div;
                    st_nxt.tx_idx = nbits + (parity_en_in ? 4'd2 : 4'd1);
                    st_nxt.tx_sh  = '1;
                    for (int i = 0; i < 8; i++) begin
                        if (4'(i) < nbits) begin
                            st_nxt.tx_sh[i] = st_r.fifo[st_r.rp][i];
                        end
                    end
                    if (parity_en_in) begin
                        st_nxt.tx_sh[nbits] = ^(st_r.fifo[st_r.rp] &
                            8'(~(9'h1FF << nbits))) ^ parity_odd_in;
                    end
                    st_nxt.txd = 1'b0;
                end
            end
            TX_SHIFT: begin
                if (st_r.tx_cnt > `ALM_CNT_W'(1)) begin
                    st_nxt.tx_cnt = st_r.tx_cnt - `ALM_CNT_W'(1);
                end else if (st_r.tx_idx == 4'd0) begin
                    st_nxt.tx_st = TX_IDLE;
                    st_nxt.txd   = 1'b1;
                end else begin
                    st_nxt.tx_cnt = tx_div;
                    st_nxt.tx_idx = st_r.tx_idx - 4'd1;
                    st_nxt.txd    = st_r.tx_sh[0];
                    st_nxt.tx_sh  = {1'b1, st_r.tx_sh[10:1]};
                end
            end
            default: st_nxt.tx_st = TX_IDLE;
        endcase
        if (st_r.brk) begin
            st_nxt.txd = 1'b0;
        end

        // Receiver
        case (st_r.rx_st)
            RX_IDLE: begin
                if (!rx_line) begin
                    st_nxt.rx_st  = RX_START;
                    st_nxt.rx_cnt = rx_div >> 1;
                end
            end
            RX_START: begin
                if (st_r.rx_cnt > `ALM_CNT_W'(1)) begin
                    st_nxt.rx_cnt = st_r.rx_cnt - `ALM_CNT_W'(1);
                end else if (!rx_line) begin
                    st_nxt.rx_act = 1'b1;
                    st_nxt.rx_st  = RX_DATA;
                    st_nxt.rx_cnt = rx_div;
                    st_nxt.rx_idx = 4'd0;
                    st_nxt.rx_sh  = 8'h00;
                    st_nxt.rx_par = parity_odd_in;
                end else begin
                    st_nxt.rx_st = RX_IDLE;
                end
            end
            RX_DATA: begin
                if (st_r.rx_cnt > `ALM_CNT_W'(1)) begin
                    st_nxt.rx_cnt = st_r.rx_cnt - `ALM_CNT_W'(1);
                end else begin
                    st_nxt.rx_cnt = rx_div;
                    st_nxt.rx_sh[st_r.rx_idx[2:0]] = rx_line;
                    st_nxt.rx_par = st_r.rx_par ^ rx_line;
                    st_nxt.rx_idx = st_r.rx_idx + 4'd1;
                    if (st_r.rx_idx == nbits - 4'd1) begin
                        st_nxt.rx_st = parity_en_in ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (st_r.rx_cnt > `ALM_CNT_W'(1)) begin
                    st_nxt.rx_cnt = st_r.rx_cnt - `ALM_CNT_W'(1);
                end else begin
                    st_nxt.rx_cnt = rx_div;
                    st_nxt.rx_par = st_r.rx_par ^ rx_line;
                    st_nxt.rx_st  = RX_STOP;
                end
            end
            RX_STOP: begin
                if (st_r.rx_cnt > `ALM_CNT_W'(1)) begin
                    st_nxt.rx_cnt = st_r.rx_cnt - `ALM_CNT_W'(1);
                end else begin
                    // Error flags change only as a character lands or on a reset
                    done_set       = 1'b1;
                    st_nxt.rx_st   = RX_IDLE;
                    st_nxt.rx_data = st_r.rx_sh;
                    st_nxt.ovr_err = st_r.rx_done;
                    st_nxt.frm_err = !rx_line;
                    st_nxt.par_err = parity_en_in && st_r.rx_par;
                    st_nxt.rx_act  = 1'b0;
                end
            end
            default: st_nxt.rx_st = RX_IDLE;
        endcase

        // Register reads and their side effects
        if (reg_rd_in) begin
            if (sel_st) begin
                st_nxt.rdata = {st_r.modem_chg, st_r.lines[1], st_r.lines[2],
                                st_r.lines[3], st_r.rx_act, st_r.lines[4],
                                2'b00, st_r.rx_done, st_r.rx_ie, st_r.modem_ie, 1'b0,
                                st_r.sec_tx, st_r.rts, st_r.dtr, 1'b0};
                st_nxt.modem_chg = 1'b0;
            end else if (sel_rb) begin
                st_nxt.rdata = {st_r.ovr_err | st_r.frm_err | st_r.par_err,
                                st_r.ovr_err, st_r.frm_err, st_r.par_err,
                                4'h0, st_r.rx_data};
            end else if (sel_tc) begin
                st_nxt.rdata = {8'h00, tready, st_r.tx_ie, 3'b000, st_r.loop,
                                1'b0, st_r.brk};
            end else begin
                st_nxt.rdata = 16'h0000;
            end
        end
        if ((reg_rd_in || reg_wr_in) && sel_rb) begin
            st_nxt.rx_done = 1'b0;
        end

        // Register writes
        if (reg_wr_in) begin
            if (sel_st) begin
                st_nxt.rx_ie    = reg_wdata_in[`ALM_ST_RX_IE];
                st_nxt.modem_ie = reg_wdata_in[`ALM_ST_MODEM_IE];
                st_nxt.sec_tx   = reg_wdata_in[`ALM_ST_SEC_TX];
                st_nxt.rts      = reg_wdata_in[`ALM_ST_RTS];
                st_nxt.dtr      = reg_wdata_in[`ALM_ST_DTR];
            end else if (sel_tc) begin
                if (reg_wdata_in[`ALM_TC_BAUD_WE]) begin
                    st_nxt.baud_code = reg_wdata_in[`ALM_TC_BAUD_HI:`ALM_TC_BAUD_LO];
                end
                st_nxt.tx_ie = reg_wdata_in[`ALM_TC_TX_IE];
                st_nxt.loop  = reg_wdata_in[`ALM_TC_LOOP];
                st_nxt.brk   = reg_wdata_in[`ALM_TC_BREAK];
            end else if (sel_tb) begin
                // A write while full is dropped; software waits for ready
                push = tready;
            end
        end

        // Transmit buffer pointers
        if (push) begin
            st_nxt.fifo[st_r.wp] = reg_wdata_in[7:0];
            st_nxt.wp            = ~st_r.wp;
        end
        if (pop) begin
            st_nxt.rp = ~st_r.rp;
        end
        st_nxt.fill = st_r.fill + {1'b0, push} - {1'b0, pop};

        // Set wins over the clear of the same cycle
        if (done_set) begin
            st_nxt.rx_done = 1'b1;
        end
        if ((st_nxt.lines[4:2] != st_r.lines[4:2]) ||
            (st_nxt.lines[1] && !st_r.lines[1])) begin
            st_nxt.modem_chg = 1'b1;
        end

        // Bus reset: terminal ready and received character survive
        if (system_bus_reset_in) begin
            st_nxt.modem_chg = 1'b0;
            st_nxt.rx_ie     = 1'b0;
            st_nxt.modem_ie  = 1'b0;
            st_nxt.sec_tx    = 1'b0;
            st_nxt.rts       = 1'b0;
            st_nxt.rx_act    = 1'b0;
            st_nxt.rx_done   = 1'b0;
            st_nxt.ovr_err   = 1'b0;
            st_nxt.frm_err   = 1'b0;
            st_nxt.par_err   = 1'b0;
            st_nxt.tx_ie     = 1'b0;
            st_nxt.loop      = 1'b0;
            st_nxt.brk       = 1'b0;
            st_nxt.fill      = 2'd0;
            st_nxt.wp        = 1'b0;
            st_nxt.rp        = 1'b0;
            st_nxt.tx_st     = TX_IDLE;
            st_nxt.txd       = 1'b1;
            st_nxt.rx_st     = RX_IDLE;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Power-up reset gives terminal ready a defined zero; bus reset does not touch it
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_r           <= '0;
            st_r.sync1     <= `ALM_LINES_RST;
            st_r.sync2     <= `ALM_LINES_RST;
            st_r.sync3     <= `ALM_LINES_RST;
            st_r.lines     <= `ALM_LINES_RST;
            st_r.baud_code <= `ALM_BAUD_RST;
            st_r.tx_st     <= TX_IDLE;
            st_r.rx_st     <= RX_IDLE;
            st_r.txd       <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_out          = st_r.rdata;
    assign rx_irq_out             = st_r.rx_done & st_r.rx_ie;
    assign modem_irq_out          = st_r.modem_chg & st_r.modem_ie;
    assign tx_irq_out             = tready & st_r.tx_ie;
    assign txd_out                = st_r.txd;
    assign terminal_ready_out     = st_r.dtr;
    assign request_to_send_out    = rts_select_in & st_r.rts;
    assign force_busy_out         = !rts_select_in & st_r.rts;
    assign secondary_tx_space_out = st_r.sec_tx;
    assign transmit_ready_out     = tready;

endmodule : alm_line

// ### src/alm_pkg.sv
// Types of the line interface: state encodings and the state record.
// Assumes alm_cfg.svh sits on the include path.
package alm_pkg;
    `include "alm_cfg.svh"

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT}                    alm_tx_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} alm_rx_t;

    typedef struct packed {
        // Lead synchronisers: bit0 data, 1 ring, 2 cts, 3 carrier, 4 secondary
        logic [4:0]                    sync1;
        logic [4:0]                    sync2;
        logic [4:0]                    sync3;
        logic [4:0]                    lines;
        // Receive status and modem controls
        logic                          modem_chg;
        logic                          rx_ie;
        logic                          modem_ie;
        logic                          sec_tx;
        logic                          rts;
        logic                          dtr;
        logic                          rx_act;
        logic                          rx_done;
        logic                          ovr_err;
        logic                          frm_err;
        logic                          par_err;
        logic [7:0]                    rx_data;
        // Transmit control
        logic [3:0]                    baud_code;
        logic                          tx_ie;
        logic                          loop;
        logic                          brk;
        // Two-entry transmit buffer
        logic [1:0][7:0]               fifo;
        logic                          wp;
        logic                          rp;
        logic [1:0]                    fill;
        // Transmitter
        alm_tx_t                       tx_st;
        logic [`ALM_CNT_W-1:0]         tx_cnt;
        logic [3:0]                    tx_idx;
        logic [10:0]                   tx_sh;
        logic                          txd;
        // Receiver
        alm_rx_t                       rx_st;
        logic [`ALM_CNT_W-1:0]         rx_cnt;
        logic [3:0]                    rx_idx;
        logic [7:0]                    rx_sh;
        logic                          rx_par;
        // Read data
        logic [15:0]                   rdata;
    } alm_state_t;
endpackage : alm_pkg

// ### testbench/alm_dataset.sv
// Data set model: modem leads and a serial sender.
// Assumes the bench clock and a 10-cycle bit time.
`timescale 1ns/10ps
module alm_dataset #(parameter int BIT = 10) (
    // Clock
    input  wire logic       clk_in,
    // Leads: ring, cts, carrier, secondary
    output logic            rxd_out,
    output logic [3:0]      leads_out
);
    initial begin
        rxd_out = 1'b1;
        leads_out = 4'h0;
    end
    // Leads settle 8 cycles, past the 3-stage sync
    task automatic set_leads(input logic [3:0] v);
        @(posedge clk_in);
        leads_out <= v;
        repeat (8) @(posedge clk_in);
    endtask : set_leads
    // Stop level 0 forces a framing fault
    task automatic send(input logic [7:0] ch, input logic stop);
        logic [9:0] f;
        f = {stop, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_out <= f[i];
            repeat (BIT) @(posedge clk_in);
        end
        rxd_out <= 1'b1;
    endtask : send
endmodule : alm_dataset

// ### testbench/alm_line_bench.sv
// Bench of the line interface: register tasks and directed tests.
// Assumes the data set model; code 15 gives 10-cycle bits here.
`timescale 1ns/10ps
module alm_line_bench;
    import alm_pkg::*;
    logic        clk_in, reset_in = 1'b1, bus_rst = 1'b0, rd = 1'b0, wr = 1'b0;
    logic        odd = 1'b0, par = 1'b0, rsel = 1'b0;
    logic [2:0]  addr = 3'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic        rx_irq, md_irq, tx_irq, txd, dtr, rts, fbusy, sec_tx, trdy, rxd;
    logic [3:0]  leads;
    int          fail_count = 0, total_checks = 0;
    alm_dataset alm_dataset_i (.clk_in(clk_in), .rxd_out(rxd), .leads_out(leads));
    alm_line #(.CLK_HZ(192000)) alm_line_i (.clk_in(clk_in), .reset_in(reset_in),
        .system_bus_reset_in(bus_rst), .reg_addr_in(addr), .reg_rd_in(rd),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .rx_irq_out(rx_irq),
        .modem_irq_out(md_irq), .tx_irq_out(tx_irq), .data_bits_in(2'h3),
        .parity_en_in(par), .parity_odd_in(odd), .rts_select_in(rsel),
        .split_speed_in(1'b0), .tx_baud_in(4'h0), .rxd_in(rxd), .ring_in(leads[3]),
        .clear_to_send_in(leads[2]), .carrier_in(leads[1]), .secondary_rx_in(leads[0]),
        .txd_out(txd), .terminal_ready_out(dtr), .request_to_send_out(rts),
        .force_busy_out(fbusy), .secondary_tx_space_out(sec_tx), .transmit_ready_out(trdy));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        @(posedge clk_in);
        #1;
        check(rdata, exp);
    endtask : rd_chk
    task automatic bus_reset;
        @(posedge clk_in);
        bus_rst <= 1'b1;
        @(posedge clk_in);
        bus_rst <= 1'b0;
        @(posedge clk_in);
        #1;
    endtask : bus_reset
    // Bounded wait; a whole frame is about 100 cycles
    task automatic wait_rx;
        int n = 0;
        while (rx_irq !== 1'b1 && n < 1000) begin
            @(posedge clk_in);
            n++;
        end
        #1;
        check({15'h0, rx_irq}, 16'h0001);
    endtask : wait_rx
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    // Whole run needs under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        results;
    end
    initial begin
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        wr_reg(3'h0, 16'h006E);
        rd_chk(3'h0, 16'h006E);
        check({12'h0, dtr, rts, fbusy, sec_tx}, 16'h000B);
        rsel <= 1'b1;
        #1 check({14'h0, rts, fbusy}, 16'h0002);
        bus_reset;
        rd_chk(3'h0, 16'h0002);
        $display("test control leads done");
        wr_reg(3'h0, 16'h0020);
        alm_dataset_i.set_leads(4'b0010);
        check({15'h0, md_irq}, 16'h0001);
        rd_chk(3'h0, 16'h9020);
        rd_chk(3'h0, 16'h1020);
        alm_dataset_i.set_leads(4'b1010);
        rd_chk(3'h0, 16'hD020);
        alm_dataset_i.set_leads(4'b0111);
        rd_chk(3'h0, 16'hB420);
        $display("test modem leads done");
        wr_reg(3'h0, 16'h0040);
        wr_reg(3'h4, 16'hF804);
        wr_reg(3'h4, 16'h0004);
        fork
            alm_dataset_i.send(8'h55, 1'b1);
            wr_reg(3'h6, 16'h0041);
        join
        wait_rx;
        rd_chk(3'h2, 16'h0041);
        check({15'h0, rx_irq}, 16'h0000);
        $display("test loopback done");
        wr_reg(3'h6, 16'h0012);
        wr_reg(3'h6, 16'h0034);
        wr_reg(3'h6, 16'h0056);
        check({15'h0, trdy}, 16'h0000);
        rd_chk(3'h4, 16'h0004);
        wait_rx;
        repeat (50) @(posedge clk_in);
        rd_chk(3'h0, 16'h3CC0);
        repeat (200) @(posedge clk_in);
        rd_chk(3'h2, 16'hC056);
        wr_reg(3'h4, 16'h0044);
        check({15'h0, tx_irq}, 16'h0001);
        wr_reg(3'h6, 16'h0007);
        wait_rx;
        rd_chk(3'h2, 16'h0007);
        $display("test overrun done");
        wr_reg(3'h4, 16'h0000);
        alm_dataset_i.send(8'hA5, 1'b0);
        wait_rx;
        rd_chk(3'h2, 16'hA0A5);
        {par, odd} <= 2'b11;
        alm_dataset_i.send(8'hA5, 1'b0);
        wait_rx;
        rd_chk(3'h2, 16'h90A5);
        bus_reset;
        rd_chk(3'h2, 16'h00A5);
        rd_chk(3'h4, 16'h0080);
        $display("test framing done");
        wr_reg(3'h4, 16'h0001);
        repeat (30) @(posedge clk_in);
        check({15'h0, txd}, 16'h0000);
        bus_reset;
        check({15'h0, txd}, 16'h0001);
        $display("test break done");
        results;
    end
endmodule : alm_line_bench

// ### testbench/alm_line_sva.sv
// Checker of register and lead behaviour of the line interface.
// Assumes binding into alm_line; sees its ports only.
`timescale 1ns/10ps
module alm_line_sva (
    input wire logic        clk_in,
    input wire logic        reset_in,
    input wire logic        system_bus_reset_in,
    input wire logic [2:0]  reg_addr_in,
    input wire logic        reg_rd_in,
    input wire logic        reg_wr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic        rx_irq_out,
    input wire logic        modem_irq_out,
    input wire logic        tx_irq_out,
    input wire logic        rts_select_in,
    input wire logic        txd_out,
    input wire logic        terminal_ready_out,
    input wire logic        request_to_send_out,
    input wire logic        force_busy_out,
    input wire logic        secondary_tx_space_out,
    input wire logic        transmit_ready_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_receive_buffer; (reg_rd_in || reg_wr_in) && reg_addr_in[2:1] == 2'd1; endsequence
    sequence s_stat; reg_rd_in && reg_addr_in[2:1] == 2'd0; endsequence
    sequence s_brk; reg_wr_in && reg_addr_in[2:1] == 2'd2 && reg_wdata_in[0]; endsequence
    property p_done_clr; s_receive_buffer |-> ##2 !rx_irq_out; endproperty
    property p_chg_clr; s_stat |-> ##2 !modem_irq_out; endproperty
    property p_brk; s_brk |-> ##3 (!txd_out) [*8]; endproperty
    property p_bus_rst;
        system_bus_reset_in |-> ##2 (txd_out && !rx_irq_out && !modem_irq_out && !tx_irq_out
            && !request_to_send_out && !force_busy_out && !secondary_tx_space_out);
    endproperty
    property p_dtr; system_bus_reset_in |=> $stable(terminal_ready_out); endproperty
    property p_rts; !rts_select_in |-> !request_to_send_out; endproperty
    property p_tx_irq; tx_irq_out |-> transmit_ready_out; endproperty
    property p_rdy_fall;
        $fell(transmit_ready_out) |-> $past(reg_wr_in) && $past(reg_addr_in[2:1]) == 2'd3;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("done not cleared");
    a_chg_clr: assert property (p_chg_clr) else $error("change not cleared");
    a_brk: assert property (p_brk) else $error("break not spacing");
    a_bus_rst: assert property (p_bus_rst) else $error("bus reset missed");
    a_dtr: assert property (p_dtr) else $error("ready lead moved");
    a_rts: assert property (p_rts) else $error("wrong lead driven");
    a_tx_irq: assert property (p_tx_irq) else $error("tx irq not ready");
    a_rdy_fall: assert property (p_rdy_fall) else $error("ready fell alone");
endmodule : alm_line_sva
bind alm_line alm_line_sva alm_line_sva_i (.clk_in(clk_in), .reset_in(reset_in),
    .system_bus_reset_in(system_bus_reset_in), .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .rx_irq_out(rx_irq_out), .modem_irq_out(modem_irq_out), .tx_irq_out(tx_irq_out),
    .rts_select_in(rts_select_in), .txd_out(txd_out),
    .terminal_ready_out(terminal_ready_out), .request_to_send_out(request_to_send_out),
    .force_busy_out(force_busy_out), .secondary_tx_space_out(secondary_tx_space_out),
    .transmit_ready_out(transmit_ready_out));
